// [core/pin_edge_if.sv]
// settled pin levels and edge strobes passed from the synchroniser
// assumes one clock domain, the system clock
`timescale 1ns/1ps

interface pin_edge_if;
  logic sck_level;  // settled clock level
  logic sck_rise;   // one-cycle pulse on clock rise
  logic sck_fall;   // one-cycle pulse on clock fall
  logic dat_level;  // settled data level, high when released
  logic dat_rise;   // one-cycle pulse on data rise
  logic dat_fall;   // one-cycle pulse on data fall

  // synchroniser drives, link engine reads
  modport source (output sck_level, sck_rise, sck_fall, dat_level, dat_rise, dat_fall);
  modport sink   (input  sck_level, sck_rise, sck_fall, dat_level, dat_rise, dat_fall);
endinterface // pin_edge_if

// [core/pin_sync.sv]
// two-stage synchroniser and edge finder for the clock and data pins
// assumes both pins are asynchronous to sys_clk_in
`timescale 1ns/1ps
`include "two_wire_defines.svh"

module pin_sync (
  // clock and reset
  input  wire logic  sys_clk_in,
  input  wire logic  reset_in,
  // raw pins
  input  wire logic  sck_in,
  input  wire logic  dat_in,
  // settled levels and edges
  pin_edge_if.source edges
);

  two_wire_pkg::sync_state_type q;  // registered state
  two_wire_pkg::sync_state_type d;  // next state

  // =====================================================================
  // next state: shift each pin through two flops, keep last value
  always_comb begin
    d          = q;
    d.sck_meta = sck_in;
    d.sck_sync = q.sck_meta;
    d.sck_prev = q.sck_sync;
    d.dat_meta = dat_in;
    d.dat_sync = q.dat_meta;
    d.dat_prev = q.dat_sync;
  end

  // =====================================================================
  // registers; data resets high, as the pull-up holds it
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      q <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    end else begin
      q <= d;
    end
  end

  // =====================================================================
  // edges only from settled stages, never from the first flop
  assign edges.sck_level = q.sck_sync;
  assign edges.sck_rise  = q.sck_sync & ~q.sck_prev;
  assign edges.sck_fall  = ~q.sck_sync & q.sck_prev;
  assign edges.dat_level = q.dat_sync;
  assign edges.dat_rise  = q.dat_sync & ~q.dat_prev;
  assign edges.dat_fall  = ~q.dat_sync & q.dat_prev;

endmodule // pin_sync

// [core/sensor_link.sv]
// device end of the two-wire sensor link: start detect, command in,
// acknowledge, reply bytes out, connection reset
// assumes an external controller makes the clock and a pull-up on data
`timescale 1ns/1ps
`include "two_wire_defines.svh"

module sensor_link #(
  parameter int unsigned RESET_TOGGLES = `TW_RESET_TOGGLES  // released clock rises that reset
) (
  // clock and reset
  input  wire logic                   sys_clk_in,
  input  wire logic                   reset_in,
  // link pins
  input  wire logic                   sck_in,
  input  wire logic                   dat_in,
  output logic                        dat_out,
  output logic                        dat_oe_out,
  // command to the sensor core
  output logic                        cmd_valid_out,
  output logic [`TW_CODE_W-1:0]       cmd_code_out,
  // reply byte from the sensor core
  input  wire logic                   tx_valid_in,
  input  wire logic [`TW_BYTE_W-1:0]  tx_byte_in,
  output logic                        tx_ready_out
);

  // =====================================================================
  // pin synchroniser
  pin_edge_if edges ();  // settled pin levels and strobes

  // the clock pin only feeds this input stage; no path drives it
  pin_sync u_sync (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .sck_in     (sck_in),
    .dat_in     (dat_in),
    .edges      (edges)
  );

  two_wire_pkg::link_state_reg_type q;  // registered state
  two_wire_pkg::link_state_reg_type d;  // next state

  // =====================================================================
  // connection reset limit
  // cut to counter width on purpose; the check below keeps it in range
  localparam logic [`TW_CNT_W-1:0] RST_LIMIT = RESET_TOGGLES[`TW_CNT_W-1:0];

  // a limit the counter cannot reach would leave the link unrecoverable
  if (RESET_TOGGLES < 1 || RESET_TOGGLES >= (1 << `TW_CNT_W)) begin : g_bad_toggles
    $error("reset toggle count does not fit the counter");
  end

  // =====================================================================
  // next state: every move but the reply load in ST_TX_WAIT waits on a pin edge, so no timeout exists
  // and a stopped clock freezes the machine outside ST_TX_WAIT
  always_comb begin
    d           = q;
    d.cmd_valid = 1'b0;
    case (q.state)
      // idle: a data fall with clock high opens a start
      two_wire_pkg::ST_IDLE: begin
        if (edges.dat_fall && edges.sck_level) begin
          d.state = two_wire_pkg::ST_START_FALL;
        end
      end
      // data low, clock high: expect clock to fall
      two_wire_pkg::ST_START_FALL: begin
        if (edges.dat_rise) begin
          d.state = two_wire_pkg::ST_IDLE;               // a stop, not a start
        end else if (edges.sck_fall) begin
          d.state = two_wire_pkg::ST_START_LOW;
        end
      end
      // clock low inside start: data must still be low at the rise
      two_wire_pkg::ST_START_LOW: begin
        if (edges.sck_rise) begin
          d.state = edges.dat_level ? two_wire_pkg::ST_IDLE
                                    : two_wire_pkg::ST_START_HIGH;
        end
      end
      // clock high again: data rise completes the start
      two_wire_pkg::ST_START_HIGH: begin
        if (edges.dat_rise) begin
          d.state   = two_wire_pkg::ST_CMD;
          d.bit_cnt = `TW_CNT_ZERO;
        end else if (edges.sck_fall) begin
          d.state = two_wire_pkg::ST_IDLE;
        end
      end
      // command bits: taken on rising edges, MSB first
      two_wire_pkg::ST_CMD: begin
        if (edges.sck_rise) begin
          // released line reads one, pulled low reads zero
          d.shreg   = {q.shreg[`TW_BYTE_W-2:0], edges.dat_level};
          d.bit_cnt = q.bit_cnt + `TW_CNT_ONE;
        end else if (edges.sck_fall && q.bit_cnt == `TW_BITS_LAST) begin
          // any other address, such as an I2C one, gets no answer
          if (q.shreg[`TW_BYTE_W-1 -: `TW_ADDR_W] == `TW_ADDR_VALUE) begin
            d.state   = two_wire_pkg::ST_ACK;
            d.dat_out = 1'b0;
            d.dat_oe  = 1'b1;
          end else begin
            d.state = two_wire_pkg::ST_IDLE;
          end
        end
      end
      // acknowledge held until the ninth fall
      two_wire_pkg::ST_ACK: begin
        if (edges.sck_fall) begin
          d.dat_oe    = 1'b0;
          d.dat_out   = 1'b1;
          d.cmd_valid = 1'b1;
          d.cmd_code  = q.shreg[`TW_CODE_W-1:0];
          d.tx_ready  = 1'b1;
          d.state     = two_wire_pkg::ST_TX_WAIT;
        end
      end
      // waiting for the core; a new start abandons the reply
      two_wire_pkg::ST_TX_WAIT: begin
        if (edges.dat_fall && edges.sck_level) begin
          d.tx_ready = 1'b0;
          d.state    = two_wire_pkg::ST_START_FALL;
        end else if (tx_valid_in) begin
          // clock is low here, so the first bit may go out at once
          d.shreg    = tx_byte_in;
          d.dat_out  = tx_byte_in[`TW_BYTE_W-1];
          d.dat_oe   = 1'b1;
          d.bit_cnt  = `TW_CNT_ONE;
          d.tx_ready = 1'b0;
          d.state    = two_wire_pkg::ST_TX_BITS;
        end
      end
      // each falling edge moves to the next bit, held through the rise
      two_wire_pkg::ST_TX_BITS: begin
        if (edges.sck_fall) begin
          if (q.bit_cnt == `TW_BITS_LAST) begin
            d.dat_oe  = 1'b0;
            d.dat_out = 1'b1;
            d.state   = two_wire_pkg::ST_TX_ACK;
          end else begin
            d.shreg   = {q.shreg[`TW_BYTE_W-2:0], 1'b0};
            d.dat_out = q.shreg[`TW_BYTE_W-2];
            d.bit_cnt = q.bit_cnt + `TW_CNT_ONE;
          end
        end
      end
      // controller pulls low to ask for another byte
      two_wire_pkg::ST_TX_ACK: begin
        if (edges.sck_rise) begin
          d.ack_low = ~edges.dat_level;
        end else if (edges.sck_fall) begin
          d.tx_ready = q.ack_low;
          d.state    = q.ack_low ? two_wire_pkg::ST_TX_WAIT
                                 : two_wire_pkg::ST_IDLE;
        end
      end
      default: begin
        d.state  = two_wire_pkg::ST_IDLE;
        d.dat_oe = 1'b0;
      end
    endcase

    // connection reset: count clock rises with data left high; only
    // counted while the pin is released, since our own drive is no sign
    if (edges.sck_rise && !q.dat_oe) begin
      if (!edges.dat_level) begin
        d.rst_cnt = `TW_CNT_ZERO;
      end else if (q.rst_cnt != RST_LIMIT) begin
        d.rst_cnt = q.rst_cnt + `TW_CNT_ONE;
      end
    end
    if (q.rst_cnt == RST_LIMIT) begin
      // interface only; the last command code is kept
      d.state    = two_wire_pkg::ST_IDLE;
      d.rst_cnt  = `TW_CNT_ZERO;
      d.dat_oe   = 1'b0;
      d.dat_out  = 1'b1;
      d.tx_ready = 1'b0;
    end
  end

  // =====================================================================
  // state register
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      q.state     <= two_wire_pkg::ST_IDLE;
      q.bit_cnt   <= `TW_CNT_ZERO;
      q.rst_cnt   <= `TW_CNT_ZERO;
      q.shreg     <= `TW_BYTE_RESET;
      q.ack_low   <= 1'b0;
      q.dat_out   <= 1'b1;
      q.dat_oe    <= 1'b0;
      q.cmd_valid <= 1'b0;
      q.cmd_code  <= `TW_CODE_RESET;
      q.tx_ready  <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // =====================================================================
  // outputs straight from the state flops
  assign dat_out       = q.dat_out;
  assign dat_oe_out    = q.dat_oe;
  assign cmd_valid_out = q.cmd_valid;
  assign cmd_code_out  = q.cmd_code;
  assign tx_ready_out  = q.tx_ready;

endmodule // sensor_link

// [core/two_wire_defines.svh]
// constants for the two-wire sensor link: field widths, codes, counts
// assumes it is included by bare name from every file that needs them
`ifndef TWO_WIRE_DEFINES_SVH
`define TWO_WIRE_DEFINES_SVH

// =====================================================================
// command framing
`define TW_ADDR_W        3        // address bits at the head of a command
`define TW_CODE_W        5        // command bits after the address
`define TW_BYTE_W        8        // bits in one framed byte
`define TW_ADDR_VALUE    3'h0     // the only address answered
`define TW_CODE_RESET    5'h00    // command code register after reset
`define TW_BYTE_RESET    8'h00    // shift register after reset

// =====================================================================
// counters
`define TW_CNT_W         4        // width of bit and toggle counters
`define TW_CNT_ZERO      4'h0     // counter clear value
`define TW_CNT_ONE       4'h1     // counter step
`define TW_BITS_LAST     4'h8     // bit count at the end of a byte
`define TW_RESET_TOGGLES 4'h9     // clock toggles with data high that reset

`endif

// [core/two_wire_pkg.sv]
// types shared by the two-wire sensor link modules
// assumes two_wire_defines.svh supplies the widths
`include "two_wire_defines.svh"

package two_wire_pkg;

  // =====================================================================
  // link state machine
  typedef enum logic [3:0] {
    ST_IDLE,        // waiting for a start pattern
    ST_START_FALL,  // data fell while clock high
    ST_START_LOW,   // clock pulsed low inside the start
    ST_START_HIGH,  // clock high again, waiting for data to rise
    ST_CMD,         // shifting in address and command bits
    ST_ACK,         // holding data low as acknowledge
    ST_TX_WAIT,     // command taken, waiting for a reply byte
    ST_TX_BITS,     // driving reply bits out
    ST_TX_ACK       // controller acknowledge slot
  } link_state_type;

  // =====================================================================
  // pin synchroniser state
  typedef struct packed {
    logic sck_meta;   // first stage, read only by second
    logic sck_sync;   // settled clock level
    logic sck_prev;   // previous settled clock level
    logic dat_meta;   // first stage, read only by second
    logic dat_sync;   // settled data level
    logic dat_prev;   // previous settled data level
  } sync_state_type;

  // =====================================================================
  // link engine state
  typedef struct packed {
    link_state_type            state;     // protocol position
    logic [`TW_CNT_W-1:0]      bit_cnt;   // bits moved in this byte
    logic [`TW_CNT_W-1:0]      rst_cnt;   // clock rises seen with data high
    logic [`TW_BYTE_W-1:0]     shreg;     // command in / reply out
    logic                      ack_low;   // controller acknowledged
    logic                      dat_out;   // level driven on data
    logic                      dat_oe;    // data pin driven
    logic                      cmd_valid; // one-cycle command pulse
    logic [`TW_CODE_W-1:0]     cmd_code;  // last accepted command
    logic                      tx_ready;  // ready for a reply byte
  } link_state_reg_type;

endpackage

// [tb/ctl_model.sv]
// controller model: makes the link clock and pulls data low
// assumes the bench resolves data with a pull-up
`timescale 1ns/1ps
module ctl_model (
  // link pins
  output logic      sck_out,
  output logic      pull_low_out,
  // resolved data wire
  input  wire logic dat_wire_in
);
  // clock stands still low outside frames, data released
  initial begin
    sck_out = 1'b0;
    pull_low_out = 1'b0;
  end
  // one clock: data set in low phase, sampled mid high phase
  task automatic clk_bit(input logic low, output logic seen);
    #200 pull_low_out = low;
    #200 sck_out = 1'b1;
    #200 seen = dat_wire_in;
    #200 sck_out = 1'b0;
  endtask
  // start pattern
  task automatic start();
    #200 sck_out = 1'b1;
    #200 pull_low_out = 1'b1;
    #200 sck_out = 1'b0;
    #400 sck_out = 1'b1;
    #200 pull_low_out = 1'b0;
    #200 sck_out = 1'b0;
  endtask
  // command byte, optional clock stop after the address
  task automatic send(input logic [7:0] b, input int gap, input logic st, output logic ack);
    logic s;
    if (st) start();
    for (int i = 7; i >= 0; i--) begin
      clk_bit(~b[i], s);
      if (i == 5) #(gap);
    end
    clk_bit(1'b0, ack);
  endtask
  // reply byte, then our own acknowledge slot
  task automatic read(input logic ackit, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b0, v[i]);
    clk_bit(ackit, s);
    #200 pull_low_out = 1'b0;
  endtask
endmodule // ctl_model

// [tb/link_chk.sv]
// assertions on the device end of the two-wire link
// assumes binding to sensor_link, sees its ports only
`timescale 1ns/1ps
`include "two_wire_defines.svh"
module link_chk (
  // clock and reset
  input wire logic                  sys_clk_in,
  input wire logic                  reset_in,
  // link pins
  input wire logic                  sck_in,
  input wire logic                  dat_in,
  input wire logic                  dat_out,
  input wire logic                  dat_oe_out,
  // command and reply
  input wire logic                  cmd_valid_out,
  input wire logic [`TW_CODE_W-1:0] cmd_code_out,
  input wire logic                  tx_valid_in,
  input wire logic [`TW_BYTE_W-1:0] tx_byte_in,
  input wire logic                  tx_ready_out
);
  // =====================================================================
  // helpers
  wire msb_w = tx_byte_in[`TW_BYTE_W-1]; // reply bit sent first
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);
  AST_RESET_VALUES: assert property ($fell(reset_in) |-> !dat_oe_out && dat_out
    && !cmd_valid_out && !tx_ready_out && cmd_code_out == `TW_CODE_RESET)
    else $error("outputs not at reset values");
  AST_PULSE_SINGLE: assert property (cmd_valid_out |=> !cmd_valid_out)
    else $error("command pulse longer than one cycle");
  AST_CODE_WITH_PULSE: assert property ($changed(cmd_code_out) |-> cmd_valid_out)
    else $error("command code moved without a pulse");
  AST_ACK_THEN_PULSE: assert property (cmd_valid_out |->
    $past(dat_oe_out) && !$past(dat_out) && !dat_oe_out)
    else $error("pulse not at the end of the acknowledge");
  AST_REPLY_MSB: assert property (tx_ready_out && tx_valid_in |=>
    dat_oe_out && !tx_ready_out && dat_out == $past(msb_w))
    else $error("reply did not start with its top bit");
  AST_BIT_AFTER_FALL: assert property (dat_oe_out && $past(dat_oe_out)
    && $changed(dat_out) |-> !$past(sck_in) && !sck_in)
    else $error("reply bit changed while clock high");
  AST_RELEASED_HIGH: assert property (!dat_oe_out |-> dat_out)
    else $error("released data pin not at one");
  AST_DRIVE_CAUSE: assert property ($rose(dat_oe_out) |->
    !dat_out || $past(tx_ready_out) && $past(tx_valid_in))
    else $error("data pin driven with no cause");
  AST_READY_RELEASED: assert property ($rose(tx_ready_out) |-> !dat_oe_out)
    else $error("ready raised while driving data");
endmodule // link_chk

bind sensor_link link_chk link_chk_inst (
  .sys_clk_in, .reset_in, .sck_in, .dat_in, .dat_out, .dat_oe_out,
  .cmd_valid_out, .cmd_code_out, .tx_valid_in, .tx_byte_in, .tx_ready_out
);

// [tb/testbench.sv]
// self-checking bench for sensor_link with a controller model
// assumes a pull-up on data, modelled by the wire resolution
`timescale 1ns/1ps
`include "two_wire_defines.svh"
module testbench;
  logic                   sys_clk_in, reset_in, sck, pull_low, dat_wire;
  logic                   dat_out, dat_oe_out, cmd_valid_out, tx_valid_in, tx_ready_out, ack;
  logic [`TW_CODE_W-1:0]  cmd_code_out, exp_code;
  logic [`TW_BYTE_W-1:0]  tx_byte_in, got;
  logic [7:0]             q[$];      // bytes offered, in order
  logic [31:0]            rnd;
  logic [4:0]             codes [5] = '{5'h03, 5'h05, 5'h07, 5'h06, 5'h1e};
  int                     err_count, compares, pulses, exp_pulses;
  // pull-up wins unless someone pulls low
  assign dat_wire = ((dat_oe_out & ~dat_out) | pull_low) ? 1'b0 : 1'b1;
  sensor_link sensor_link_inst (.sys_clk_in, .reset_in, .sck_in(sck), .dat_in(dat_wire),
    .dat_out, .dat_oe_out, .cmd_valid_out, .cmd_code_out, .tx_valid_in, .tx_byte_in,
    .tx_ready_out);
  ctl_model ctl_model_inst (.sck_out(sck), .pull_low_out(pull_low), .dat_wire_in(dat_wire));
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) if (cmd_valid_out === 1'b1) pulses++;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // bounded wait for the ready level
  task automatic wait_ready(input logic v);
    int n;
    n = 0;
    while (tx_ready_out !== v && n < 40) begin
      @(posedge sys_clk_in);
      n++;
    end
    if (n == 40) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  // one command through the model, then compare with expectation
  task automatic do_cmd(input logic [2:0] a, input logic [4:0] c, input int gap, input logic st);
    logic ok;
    ok = st && a == 3'h0;
    ctl_model_inst.send({a, c}, gap, st, ack);
    if (ok) begin
      exp_code = c;
      exp_pulses++;
      wait_ready(1'b1);
    end else repeat (10) @(posedge sys_clk_in);
    repeat (2) @(posedge sys_clk_in);
    check(ack, !ok);
    check(cmd_code_out, exp_code);
    check(pulses, exp_pulses);
  endtask
  initial begin
    reset_in = 1'b1;
    tx_valid_in = 1'b0;
    tx_byte_in = 8'h00;
    exp_code = 5'h00;
    rnd = 32'h1f5fbd67;
    repeat (5) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    @(posedge sys_clk_in);
    check({dat_oe_out, dat_out, cmd_valid_out, tx_ready_out, cmd_code_out}, 9'h080);
    $display("test reset done");
    foreach (codes[i]) do_cmd(3'h0, codes[i], 0, 1'b1);
    rnd = lfsr(rnd);
    do_cmd(3'h0, rnd[4:0], 20000, 1'b1);
    $display("test commands done");
    rnd = lfsr(rnd);
    do_cmd(rnd[2:0] | 3'h4, rnd[7:3], 0, 1'b1);
    $display("test refused address done");
    // the refused frame left the link idle; a good command opens a reply
    do_cmd(3'h0, 5'h07, 0, 1'b1);
    for (int k = 0; k < 2; k++) begin
      rnd = lfsr(rnd);
      q.push_back(rnd[7:0]);
      @(posedge sys_clk_in);
      tx_byte_in <= rnd[7:0];
      tx_valid_in <= 1'b1;
      @(posedge sys_clk_in);
      tx_valid_in <= 1'b0;
      ctl_model_inst.read(k == 0, got);
      check(got, q.pop_front());
      if (k == 0) begin
        wait_ready(1'b1);
      end else begin
        // a byte offered while not ready must be ignored
        tx_valid_in <= 1'b1;
        @(posedge sys_clk_in);
        tx_valid_in <= 1'b0;
        repeat (10) @(posedge sys_clk_in);
      end
      check({dat_oe_out, tx_ready_out}, k == 0);
    end
    $display("test reply done");
    do_cmd(3'h0, 5'h07, 0, 1'b1);
    for (int i = 0; i < 9; i++) ctl_model_inst.clk_bit(1'b0, ack);
    repeat (10) @(posedge sys_clk_in);
    check({dat_oe_out, tx_ready_out}, 0);
    do_cmd(3'h0, 5'h05, 0, 1'b0);
    do_cmd(3'h0, 5'h05, 0, 1'b1);
    $display("test connection reset done");
    tally_and_finish();
  end
endmodule // testbench
